// ### bench/pop_line_model.sv
// Line side model: remote path equipment sending receive overhead
module pop_line_model (
    input  wire logic       mclk_i,
    output logic            frame_o,
    output logic      [7:0] k1_o,
    output logic      [7:0] label_o,
    output logic      [3:0] fe_o,
    output logic            spe_o,
    output logic      [3:0] errs_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {frame_o, spe_o, k1_o, label_o, fe_o, errs_o} = '0;
    end
    // ========================================================
    // Bytes hold only on the pulse; inverted after so stale data never matches
    task automatic frame(input logic [7:0] k1, input logic [7:0] lab, input logic [3:0] fe);
        @(posedge mclk_i);
        frame_o <= 1'b1;
        {k1_o, label_o, fe_o} <= {k1, lab, fe};
        @(posedge mclk_i);
        frame_o <= 1'b0;
        {k1_o, label_o, fe_o} <= ~{k1, lab, fe};
        @(posedge mclk_i);
    endtask
    task automatic spe(input logic [3:0] e);
        @(posedge mclk_i);
        spe_o <= 1'b1;
        errs_o <= e;
        @(posedge mclk_i);
        spe_o <= 1'b0;
        errs_o <= ~e;
    endtask
endmodule // pop_line_model

// ### bench/pop_path_ctl_test.sv
// Self-checking bench for the path overhead and pointer control block
module pop_path_ctl_test;
    import pop_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} pop_row_t;
    logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, txf = 1'b0, fix = 1'b0;
    logic [7:0] adr = '0, wd = '0, calc = 8'h3C, k1, lab, rdata, k1o, par, h1, h2;
    logic [2:0] st = '0;
    logic [3:0] fe, errs;
    logic [9:0] ofs;
    logic       fr, spe, fill, poll, irq, sinc, sdec;
    int         n_errors = 0, compares = 0, cyc = 0;
    pop_row_t   rows [6] = '{'{ADR_ENABLES, 8'hFF, 8'hAF}, '{ADR_TX_POH, 8'hFF, 8'h03},
        '{ADR_PAR_CTL, 8'hFF, 8'h20}, '{ADR_TX_K1, 8'h5A, 8'h5A},
        '{8'h7F, 8'hFF, 8'h00}, '{ADR_TX_POH, 8'h02, 8'h02}};
    always #20 clk = ~clk;
    pop_line_model u_line (.mclk_i(clk), .frame_o(fr), .k1_o(k1), .label_o(lab), .fe_o(fe),
        .spe_o(spe), .errs_o(errs));
    pop_path_ctl u_dut (.mclk_i(clk), .rst_n_i(rst_n), .adr_i(adr), .wdata_i(wd), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .rx_frame_i(fr), .rx_k1_i(k1), .rx_k2_i(k1),
        .rx_label_i(lab), .pointer_loss_status_i(st[2]), .path_alarm_status_i(st[1]),
        .path_remote_defect_status_i(st[0]), .rx_spe_done_i(spe), .rx_parity_errs_i(errs),
        .rx_far_end_i(fe), .fixed_pointer_mode_i(fix), .tx_frame_i(txf),
        .tx_parity_calc_i(calc), .tx_k1_o(k1o), .tx_parity_o(par), .tx_alarm_fill_o(fill),
        .tx_h1_o(h1), .tx_h2_o(h2), .tx_spe_offset_o(ofs), .tx_stuff_inc_o(sinc),
        .tx_stuff_dec_o(sdec), .tc_poll_o(poll), .irq_o(irq));
    // ========================================================
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        {adr, wd} <= {a, d};
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        @(posedge clk);
        rd <= 1'b1;
        adr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(nm, rdata, e);
    endtask
    task automatic txfr;
        @(posedge clk);
        txf <= 1'b1;
        @(posedge clk);
        txf <= 1'b0;
        @(negedge clk);
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Ceiling well above the roughly 160 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            report_and_stop;
        end
    end
    // ========================================================
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdc(ADR_PTR_CTL, 8'h00, "ptr_ctl_reset");
        rdc(ADR_PAR_CTL, 8'h00, "par_ctl_reset");
        foreach (rows[i]) begin
            wrr(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e, "reg_row");
        end
        chk("tx_k1", k1o, 8'h5A);
        chk("inverted_parity", par, 8'hC3);
        wrr(ADR_TX_POH, 8'h01);
        repeat (2) @(negedge clk);
        chk("plain_parity", par, 8'h3C);
        chk("alarm_fill", fill, 1'b1);
        txfr;
        chk("alarm_ptr", {h1, h2}, 16'hFFFF);
        wrr(ADR_TX_POH, 8'h00);
        repeat (2) u_line.frame(8'h55, 8'h42, 4'h0);
        rdc(ADR_RX_K1, 8'h00, "k1_two_frames");
        u_line.frame(8'h55, 8'h42, 4'h0);
        rdc(ADR_RX_K2, 8'h55, "k2_three_frames");
        repeat (2) u_line.frame(8'h55, 8'h42, 4'h0);
        @(negedge clk);
        chk("irq_label", irq, 1'b1);
        rdc(ADR_FLAGS, 8'h80, "label_flag");
        chk("irq_cleared", irq, 1'b0);
        rdc(ADR_LABEL, 8'h42, "label_byte");
        @(posedge clk);
        st <= 3'b010;
        rdc(ADR_STATUS, 8'h08, "live_status");
        rdc(ADR_FLAGS, 8'h08, "alarm_change");
        rdc(ADR_FLAGS, 8'h00, "flags_cleared");
        wrr(ADR_ENABLES, 8'h00);
        repeat (2) u_line.spe(4'h5);
        u_line.frame(8'h55, 8'h13, 4'h4);
        wrr(ADR_PAR_CTL, 8'h00);
        u_line.spe(4'h8);
        @(negedge clk);
        chk("irq_masked", irq, 1'b0);
        wrr(ADR_ENABLES, 8'h03);
        repeat (2) @(negedge clk);
        chk("irq_enabled", irq, 1'b1);
        wrr(ADR_MASTER, 8'h00);
        @(negedge clk);
        chk("tc_poll", poll, 1'b1);
        rdc(ADR_PAR_LO, 8'h0A, "parity_low");
        rdc(ADR_PAR_HI, 8'h00, "parity_high");
        rdc(ADR_FE_LO, 8'h04, "far_end_low");
        rdc(ADR_FLAGS, 8'h03, "err_flags");
        fork
            wrr(ADR_FE_LO, 8'h00);
            u_line.spe(4'h2);
        join
        rdc(ADR_PAR_LO, 8'h02, "coincident_poll");
        wrr(ADR_PTR_LO, 8'h10);
        wrr(ADR_PTR_HI, 8'h60);
        wrr(ADR_PTR_CTL, 8'h10);
        txfr;
        chk("load_h1", h1, 8'h60);
        chk("load_h2", h2, 8'h10);
        chk("load_offset", ofs, 10'h010);
        rdc(ADR_PTR_CTL, 8'h00, "load_cleared");
        wrr(ADR_PTR_CTL, 8'h02);
        txfr;
        chk("inc_h2", h2, 8'hBA);
        chk("inc_stuff", sinc, 1'b1);
        txfr;
        chk("after_inc_h2", h2, 8'h11);
        rdc(ADR_PTR_CTL, 8'h00, "inc_cleared");
        @(posedge clk);
        fix <= 1'b1;
        wrr(ADR_PTR_CTL, 8'h02);
        txfr;
        chk("fixed_h2", h2, 8'h11);
        chk("fixed_stuff", sinc, 1'b0);
        rdc(ADR_PTR_CTL, 8'h02, "inc_held");
        @(posedge clk);
        fix <= 1'b0;
        wrr(ADR_PTR_CTL, 8'h24);
        txfr;
        chk("spaced_dec", sdec, 1'b0);
        txfr;
        chk("dec_stuff", sdec, 1'b1);
        chk("dec_h2", h2, 8'h44);
        wrr(ADR_PTR_LO, 8'h33);
        wrr(ADR_PTR_HI, 8'h90);
        wrr(ADR_PTR_CTL, 8'h48);
        wrr(ADR_PTR_CTL, 8'h08);
        txfr;
        chk("force_ptr", {h1, h2}, 16'h9033);
        chk("force_offset", ofs, 10'h010);
        wrr(ADR_PTR_CTL, 8'h00);
        txfr;
        chk("normal_ptr", {h1, h2}, 16'h6010);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rdc(ADR_ENABLES, 8'h00, "enables_reset");
        chk("h2_reset", h2, 8'h00);
        report_and_stop;
    end
endmodule // pop_path_ctl_test

// ### rtl/pop_cnt_if.sv
// Carrier between the control block and one snapshot error counter
interface pop_cnt_if;
    logic [3:0]  add;
    logic        poll;
    logic [15:0] hold;
    modport ctl (output add, output poll, input hold);
    modport cnt (input add, input poll, output hold);
endinterface : pop_cnt_if

// ### rtl/pop_err_counter.sv
// Sixteen-bit error accumulator with snapshot-and-clear holding register
module pop_err_counter (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    pop_cnt_if.cnt    bus
);
    logic [15:0] accum_q;
    logic [15:0] hold_q;

    // ========================================================
    // Accumulate and snapshot
    // Coincident errors go into the snapshot, never dropped
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            accum_q <= 16'h0000;
            hold_q  <= 16'h0000;
        end else if (bus.poll) begin
            hold_q  <= accum_q + {12'h000, bus.add};
            accum_q <= 16'h0000;
        end else begin
            accum_q <= accum_q + {12'h000, bus.add};
        end
    end

    assign bus.hold = hold_q;

    // ========================================================
    // Checks
    snap_sum_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        bus.poll |=> hold_q == $past(accum_q) + {12'h000, $past(bus.add)})
        else $error("snapshot lost a coincident error");
    clear_after_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        bus.poll |=> accum_q == 16'h0000)
        else $error("accumulator not cleared by poll");
endmodule : pop_err_counter

// ### rtl/pop_path_ctl.sv
// Path overhead monitor, transmit overhead insertion and pointer generator
// Behaviour
// - Programmed K1 sent in every frame
// - Received K1/K2 update after three equal frames
// - Status register shows live pointer/alarm/defect
// - Label flag after five mismatching frames
// - Hold label byte that caused mismatch
// - Change flags set, cleared by read
// - Parity and far-end flags, cleared by read
// - Enable bits gate each path interrupt
// - Sixteen-bit parity error counter, two bytes
// - Counter or master write snapshots and clears
// - Coincident error counted during poll
// - Master write polls all section counters
// - Sixteen-bit far-end error counter, two bytes
// - Block mode counts one per errored SPE
// - Invert bit corrupts transmitted parity byte
// - Alarm insert fills SPE and pointer ones
// - Force sends programmed pointer, at least once
// - Spacing bit limits stuffs to one per four
// - Load legal pointer next frame, then clear
// - New data flag forced or normal pattern
// - Stuff bits act once, blocked by fixed mode
// - Ten-bit pointer from two registers
// - Flag value from high nibble
module pop_path_ctl
    import pop_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] adr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic       rx_frame_i,
    input  wire logic [7:0] rx_k1_i,
    input  wire logic [7:0] rx_k2_i,
    input  wire logic [7:0] rx_label_i,
    input  wire logic       pointer_loss_status_i,
    input  wire logic       path_alarm_status_i,
    input  wire logic       path_remote_defect_status_i,
    input  wire logic       rx_spe_done_i,
    input  wire logic [3:0] rx_parity_errs_i,
    input  wire logic [3:0] rx_far_end_i,
    input  wire logic       fixed_pointer_mode_i,
    input  wire logic       tx_frame_i,
    input  wire logic [7:0] tx_parity_calc_i,
    output logic      [7:0] tx_k1_o,
    output logic      [7:0] tx_parity_o,
    output logic            tx_alarm_fill_o,
    output logic      [7:0] tx_h1_o,
    output logic      [7:0] tx_h2_o,
    output logic      [9:0] tx_spe_offset_o,
    output logic            tx_stuff_inc_o,
    output logic            tx_stuff_dec_o,
    output logic            tc_poll_o,
    output logic            irq_o
);
    import pop_pkg::*;

    // ========================================================
    // Registers
    logic [7:0] tx_aps_first_byte_value_q;
    logic [7:0] enables_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic [7:0] par_ctl_q;
    logic [7:0] poh_ctl_q;
    logic [7:0] ptr_ctl_q;
    logic [7:0] ptr_lo_q;
    logic [7:0] ptr_hi_q;
    logic [7:0] captured_label_byte_q;
    logic [7:0] rx_k1_q, rx_k2_q, k1_cand_q, k2_cand_q;
    logic [1:0] k1_run_q, k2_run_q;
    logic [2:0] label_run_q;
    logic [2:0] status_prev_q;
    logic [9:0] ptr_q;
    logic [1:0] since_stuff_q;
    logic       force_pend_q;

    wire logic [9:0] programmed_pointer_value = {ptr_hi_q[1:0], ptr_lo_q};
    wire logic [3:0] new_data_flag_value = ptr_hi_q[7:4];
    wire logic [2:0] status_now = {pointer_loss_status_i, path_alarm_status_i,
                                   path_remote_defect_status_i};
    wire logic       wr_hit_flags = rd_i && (adr_i == ADR_FLAGS);
    wire logic       poll = wr_i && (adr_i == ADR_MASTER || adr_i == ADR_PAR_LO ||
                            adr_i == ADR_PAR_HI || adr_i == ADR_FE_LO ||
                            adr_i == ADR_FE_HI);

    pop_cnt_if par_bus ();
    pop_cnt_if fe_bus ();

    // ========================================================
    // Counters
    logic [3:0] par_add, fe_add;
    always_comb begin
        par_add = 4'h0;
        if (rx_spe_done_i && rx_parity_errs_i != 4'h0) begin
            if (par_ctl_q[B_BLK]) par_add = 4'h1;
            else if (rx_parity_errs_i > MAX_ERR) par_add = MAX_ERR;
            else par_add = rx_parity_errs_i;
        end
        // Far-end codes above the maximum carry no errors
        fe_add = (rx_frame_i && rx_far_end_i <= MAX_ERR) ? rx_far_end_i : 4'h0;
    end

    assign par_bus.add  = par_add;
    assign par_bus.poll = poll;
    assign fe_bus.add   = fe_add;
    assign fe_bus.poll  = poll;

    pop_err_counter u_par_cnt (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(par_bus));
    pop_err_counter u_fe_cnt  (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(fe_bus));

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) tc_poll_o <= 1'b0;
        else tc_poll_o <= wr_i && (adr_i == ADR_MASTER);
    end

    // ========================================================
    // Software written registers
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_aps_first_byte_value_q <= 8'h00;
            enables_q <= 8'h00;
            par_ctl_q <= 8'h00;
            poh_ctl_q <= 8'h00;
            ptr_lo_q  <= 8'h00;
            ptr_hi_q  <= 8'h00;
        end else if (wr_i) begin
            unique case (adr_i)
                ADR_TX_K1:   tx_aps_first_byte_value_q <= wdata_i;
                ADR_ENABLES: enables_q <= wdata_i & FLAG_MASK;
                ADR_PAR_CTL: par_ctl_q <= wdata_i & BLK_MASK;
                ADR_TX_POH:  poh_ctl_q <= wdata_i & POH_MASK;
                ADR_PTR_LO:  ptr_lo_q  <= wdata_i;
                ADR_PTR_HI:  ptr_hi_q  <= wdata_i;
                default:     ;
            endcase
        end
    end

    // ========================================================
    // Receive K1/K2 persistence
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rx_k1_q <= 8'h00;
            rx_k2_q <= 8'h00;
            k1_cand_q <= 8'h00;
            k2_cand_q <= 8'h00;
            k1_run_q <= 2'h0;
            k2_run_q <= 2'h0;
        end else if (rx_frame_i) begin
            k1_cand_q <= rx_k1_i;
            k2_cand_q <= rx_k2_i;
            k1_run_q <= (rx_k1_i == k1_cand_q && k1_run_q != K_PERSIST) ? k1_run_q + 2'h1
                        : (rx_k1_i == k1_cand_q ? K_PERSIST : 2'h1);
            k2_run_q <= (rx_k2_i == k2_cand_q && k2_run_q != K_PERSIST) ? k2_run_q + 2'h1
                        : (rx_k2_i == k2_cand_q ? K_PERSIST : 2'h1);
            if (rx_k1_i == k1_cand_q && k1_run_q == K_PERSIST - 2'h1)
                rx_k1_q <= rx_k1_i;
            if (rx_k2_i == k2_cand_q && k2_run_q == K_PERSIST - 2'h1)
                rx_k2_q <= rx_k2_i;
        end
    end

    // ========================================================
    // Label mismatch and event flags
    wire logic label_bad   = rx_frame_i && rx_label_i != EXP_LABEL;
    wire logic label_event = label_bad && label_run_q == LABEL_FAIL - 3'h1;

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            label_run_q <= 3'h0;
            captured_label_byte_q <= 8'h00;
        end else if (rx_frame_i) begin
            if (!label_bad) label_run_q <= 3'h0;
            else if (label_run_q != LABEL_FAIL) label_run_q <= label_run_q + 3'h1;
            if (label_event) captured_label_byte_q <= rx_label_i;
        end
    end

    always_comb begin
        flags_d = wr_hit_flags ? 8'h00 : flags_q;
        // Setting after the read clear so a coincident event survives
        if (label_event) flags_d[B_LABEL] = 1'b1;
        if (status_now[2] != status_prev_q[2]) flags_d[B_LOSS] = 1'b1;
        if (status_now[1] != status_prev_q[1]) flags_d[B_ALARM] = 1'b1;
        if (status_now[0] != status_prev_q[0]) flags_d[B_RDEF] = 1'b1;
        if (par_add != 4'h0) flags_d[B_PAR] = 1'b1;
        if (fe_add != 4'h0) flags_d[B_FE] = 1'b1;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            flags_q <= 8'h00;
            status_prev_q <= 3'h0;
            irq_o <= 1'b0;
        end else begin
            flags_q <= flags_d;
            status_prev_q <= status_now;
            irq_o <= |(flags_d & enables_q);
        end
    end

    // ========================================================
    // Read data
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (rd_i) begin
            unique case (adr_i)
                ADR_TX_K1:   rdata_o <= tx_aps_first_byte_value_q;
                ADR_RX_K1:   rdata_o <= rx_k1_q;
                ADR_RX_K2:   rdata_o <= rx_k2_q;
                ADR_STATUS:  rdata_o <= {2'h0, status_now[2], 1'b0, status_now[1:0],
                                         2'h0};
                ADR_FLAGS:   rdata_o <= flags_q;
                ADR_ENABLES: rdata_o <= enables_q;
                ADR_LABEL:   rdata_o <= captured_label_byte_q;
                ADR_PAR_LO:  rdata_o <= par_bus.hold[7:0];
                ADR_PAR_HI:  rdata_o <= par_bus.hold[15:8];
                ADR_FE_LO:   rdata_o <= fe_bus.hold[7:0];
                ADR_FE_HI:   rdata_o <= fe_bus.hold[15:8];
                ADR_PAR_CTL: rdata_o <= par_ctl_q;
                ADR_TX_POH:  rdata_o <= poh_ctl_q;
                ADR_PTR_CTL: rdata_o <= ptr_ctl_q;
                ADR_PTR_LO:  rdata_o <= ptr_lo_q;
                ADR_PTR_HI:  rdata_o <= ptr_hi_q;
                default:     rdata_o <= 8'h00;
            endcase
        end
    end

    // ========================================================
    // Pointer generator decisions
    wire logic stuff_ok  = !ptr_ctl_q[B_SPACE] || since_stuff_q == SPACING;
    wire logic do_alarm  = poh_ctl_q[B_INS];
    wire logic do_load   = !do_alarm && ptr_ctl_q[B_LOAD];
    wire logic do_force  = !do_alarm && !do_load && (ptr_ctl_q[B_FRC] || force_pend_q);
    wire logic stuff_sel = !do_alarm && !do_load && !do_force && !fixed_pointer_mode_i
                           && stuff_ok;
    wire logic do_inc    = stuff_sel && ptr_ctl_q[B_INC];
    wire logic do_dec    = stuff_sel && !ptr_ctl_q[B_INC] && ptr_ctl_q[B_DEC];
    wire logic load_ok   = programmed_pointer_value <= PTR_MAX;
    wire logic [3:0] newf = (ptr_ctl_q[B_NEWF] || (do_load && load_ok))
                            ? new_data_flag_value : NEWF_NORMAL;
    logic [9:0] send_ptr;

    always_comb begin
        send_ptr = ptr_q;
        if (do_force) send_ptr = programmed_pointer_value;
        else if (do_load && load_ok) send_ptr = programmed_pointer_value;
        else if (do_inc) send_ptr = ptr_q ^ INC_MASK;
        else if (do_dec) send_ptr = ptr_q ^ DEC_MASK;
    end

    // ========================================================
    // Pointer control register with hardware clears
    // A software write in the same cycle wins over the clear
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ptr_ctl_q <= 8'h00;
        end else if (wr_i && adr_i == ADR_PTR_CTL) begin
            ptr_ctl_q <= wdata_i & PTRC_MASK;
        end else if (tx_frame_i) begin
            if (do_load) ptr_ctl_q[B_LOAD] <= 1'b0;
            if (do_inc) ptr_ctl_q[B_INC] <= 1'b0;
            if (do_dec) ptr_ctl_q[B_DEC] <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            force_pend_q <= 1'b0;
        end else if (wr_i && adr_i == ADR_PTR_CTL && wdata_i[B_FRC]) begin
            force_pend_q <= 1'b1;
        end else if (tx_frame_i && do_force) begin
            force_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            ptr_q <= 10'h000;
            since_stuff_q <= SPACING;
        end else if (tx_frame_i) begin
            if (do_load && load_ok) ptr_q <= programmed_pointer_value;
            else if (do_inc) ptr_q <= (ptr_q == PTR_MAX) ? 10'h000 : ptr_q + 10'h001;
            else if (do_dec) ptr_q <= (ptr_q == 10'h000) ? PTR_MAX : ptr_q - 10'h001;
            if (do_inc || do_dec) since_stuff_q <= 2'h0;
            else if (since_stuff_q != SPACING) since_stuff_q <= since_stuff_q + 2'h1;
        end
    end

    // ========================================================
    // Transmit overhead outputs; pointer bytes, offset and stuff flags held for the frame
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            tx_k1_o <= 8'h00;
            tx_parity_o <= 8'h00;
            tx_alarm_fill_o <= 1'b0;
            tx_h1_o <= 8'h00;
            tx_h2_o <= 8'h00;
            tx_spe_offset_o <= 10'h000;
            tx_stuff_inc_o <= 1'b0;
            tx_stuff_dec_o <= 1'b0;
        end else begin
            tx_k1_o <= tx_aps_first_byte_value_q;
            tx_parity_o <= tx_parity_calc_i ^ {8{poh_ctl_q[B_INV]}};
            tx_alarm_fill_o <= do_alarm;
            if (tx_frame_i) begin
                tx_h1_o <= do_alarm ? ALL_ONES : {newf, SS_BITS, send_ptr[9:8]};
                tx_h2_o <= do_alarm ? ALL_ONES : send_ptr[7:0];
                tx_spe_offset_o <= (do_load && load_ok) ? programmed_pointer_value : ptr_q;
                tx_stuff_inc_o <= do_inc;
                tx_stuff_dec_o <= do_dec;
            end
        end
    end

    // ========================================================
    // Checks
    sequence frame_with_fixed;
        tx_frame_i && fixed_pointer_mode_i;
    endsequence

    label_five_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        label_event |-> label_run_q == 3'h4 && label_bad)
        else $error("label flag not on fifth bad frame");
    label_flag_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        label_event |=> flags_q[B_LABEL] && captured_label_byte_q == $past(rx_label_i))
        else $error("label flag or captured byte missing");
    flag_read_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        wr_hit_flags && status_now == status_prev_q && par_add == 4'h0
        && fe_add == 4'h0 && !label_event |=> flags_q == 8'h00)
        else $error("flags not cleared by read");
    set_wins_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        par_add != 4'h0 |=> flags_q[B_PAR])
        else $error("parity flag lost");
    irq_gate_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ##1 irq_o == |($past(flags_d) & $past(enables_q)))
        else $error("interrupt does not follow enabled flags");
    blk_mode_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        par_ctl_q[B_BLK] |-> par_add <= 4'h1)
        else $error("block mode counts more than one");
    parity_inv_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        poh_ctl_q[B_INV] |=> tx_parity_o == ~$past(tx_parity_calc_i))
        else $error("parity byte not inverted");
    alarm_fill_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_frame_i && do_alarm |=> tx_h1_o == ALL_ONES && tx_h2_o == ALL_ONES)
        else $error("alarm did not fill pointer bytes");
    fixed_block_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        frame_with_fixed |=> !tx_stuff_inc_o && !tx_stuff_dec_o)
        else $error("stuff while pointer fixed");
    spacing_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        ptr_ctl_q[B_SPACE] && (do_inc || do_dec) |-> since_stuff_q == SPACING)
        else $error("stuffs closer than four frames");
    load_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tx_frame_i && do_load && !(wr_i && adr_i == ADR_PTR_CTL) |=> !ptr_ctl_q[B_LOAD])
        else $error("load bit not cleared");
    k_update_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        rx_frame_i && rx_k1_i != k1_cand_q |=> rx_k1_q == $past(rx_k1_q))
        else $error("receive K1 updated early");
endmodule : pop_path_ctl

// ### rtl/pop_pkg.sv
// Shared constants for the path overhead and pointer control block
package pop_pkg;
    // ========================================================
    // Register offsets
    localparam logic [7:0] ADR_MASTER  = 8'h00;
    localparam logic [7:0] ADR_TX_K1   = 8'h24;
    localparam logic [7:0] ADR_RX_K1   = 8'h26;
    localparam logic [7:0] ADR_RX_K2   = 8'h27;
    localparam logic [7:0] ADR_STATUS  = 8'h30;
    localparam logic [7:0] ADR_FLAGS   = 8'h31;
    localparam logic [7:0] ADR_ENABLES = 8'h33;
    localparam logic [7:0] ADR_LABEL   = 8'h37;
    localparam logic [7:0] ADR_PAR_LO  = 8'h38;
    localparam logic [7:0] ADR_PAR_HI  = 8'h39;
    localparam logic [7:0] ADR_FE_LO   = 8'h3A;
    localparam logic [7:0] ADR_FE_HI   = 8'h3B;
    localparam logic [7:0] ADR_PAR_CTL = 8'h3D;
    localparam logic [7:0] ADR_TX_POH  = 8'h40;
    localparam logic [7:0] ADR_PTR_CTL = 8'h41;
    localparam logic [7:0] ADR_PTR_LO  = 8'h45;
    localparam logic [7:0] ADR_PTR_HI  = 8'h46;
    // ========================================================
    // Field positions
    localparam int B_LABEL = 7;
    localparam int B_LOSS  = 5;
    localparam int B_ALARM = 3;
    localparam int B_RDEF  = 2;
    localparam int B_PAR   = 1;
    localparam int B_FE    = 0;
    localparam int B_BLK   = 5;
    localparam int B_INV   = 1;
    localparam int B_INS   = 0;
    localparam int B_FRC   = 6;
    localparam int B_SPACE = 5;
    localparam int B_LOAD  = 4;
    localparam int B_NEWF  = 3;
    localparam int B_DEC   = 2;
    localparam int B_INC   = 1;
    localparam logic [7:0] FLAG_MASK   = 8'hAF;
    localparam logic [7:0] STATUS_MASK = 8'h2C;
    localparam logic [7:0] PTRC_MASK   = 8'h7E;
    localparam logic [7:0] POH_MASK    = 8'h03;
    localparam logic [7:0] BLK_MASK    = 8'h20;
    // ========================================================
    // Frame counts and pointer values
    localparam logic [1:0] K_PERSIST   = 2'h3;
    localparam logic [2:0] LABEL_FAIL  = 3'h5;
    localparam logic [7:0] EXP_LABEL   = 8'h13;
    localparam logic [3:0] MAX_ERR     = 4'h8;
    localparam logic [3:0] NEWF_NORMAL = 4'h6;
    localparam logic [1:0] SS_BITS     = 2'h0;
    localparam logic [9:0] PTR_MAX     = 10'h30E;
    localparam logic [9:0] INC_MASK    = 10'h2AA;
    localparam logic [9:0] DEC_MASK    = 10'h155;
    localparam logic [1:0] SPACING     = 2'h3;
    localparam logic [7:0] ALL_ONES    = 8'hFF;
endpackage : pop_pkg
